//--- design/wrs_pkg.sv
package wrs_pkg;

  // core clock
  localparam int CLK_PERIOD_NS = 8;

  // register map, 8-bit data
  localparam logic [7:0] ADDR_RST_STATUS = 8'h35;
  localparam logic [7:0] ADDR_GUARD_CTRL = 8'h60;

  // guard control fields
  localparam int GC_IRQ_FLAG = 7;
  localparam int GC_IRQ_EN = 6;
  localparam int GC_PRESC_HI = 5;
  localparam int GC_CHANGE_EN = 4;
  localparam int GC_RESET_EN = 3;
  localparam int GC_PRESC_LO_MSB = 2;

  // reset status fields
  localparam int RS_GUARD = 3;
  localparam int RS_DROOP = 2;
  localparam int RS_EXT = 1;
  localparam int RS_ONSET = 0;

  localparam logic [7:0] GUARD_CTRL_RESET = 8'h00;
  localparam logic [3:0] RST_STATUS_RESET = 4'h1;

  // timed change window, core clock cycles
  localparam logic [2:0] CHANGE_WINDOW_CYC = 3'h4;

  // guard time-out: base count doubled per code step, top legal code
  localparam int GUARD_BASE_CYC = 2048;
  localparam logic [3:0] PRESC_MAX_CODE = 4'h9;
  localparam int GUARD_CNT_W = 21;

  // droop detector: all ones on the level fuse means detector off
  localparam logic [2:0] DROOP_LEVEL_OFF = 3'h7;
  localparam int DROOP_MIN_NS = 2000;
  localparam int DROOP_MIN_CYC = (DROOP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DROOP_CNT_W = 9;

  // start-up delay choices
  localparam int STARTUP_SHORT_CYC = 16;
  localparam int STARTUP_MID_US = 4100;
  localparam int STARTUP_LONG_US = 65000;
  localparam int STARTUP_MID_CYC = (STARTUP_MID_US * 1000) / CLK_PERIOD_NS;
  localparam int STARTUP_LONG_CYC = (STARTUP_LONG_US * 1000) / CLK_PERIOD_NS;
  localparam int DLY_CNT_W = 24;

  typedef enum logic [1:0] {
    WRS_HOLD,
    WRS_DELAY,
    WRS_GUARD_PULSE,
    WRS_RUN
  } wrs_rst_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } wrs_bus_req_s;

  typedef struct packed {
    logic supply_ok;
    logic ext_reset_n;
    logic droop_low;
    logic droop_high;
  } wrs_analog_s;

endpackage

//--- design/wrs_top.sv
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/10ps

// Summary of operation
// - hold reset while supply below onset level
// - onset release runs start-up delay first
// - supply drop reasserts reset at once
// - low reset pin resets the chip
// - pin release runs start-up delay
// - pin disable fuse ignores reset pin
// - droop resets now, releases via delay
// - droop counted only after minimum duration
// - level fuse picks droop level, hysteresis band
// - guard reset is one-cycle pulse, then delay
// - bandgap on for droop, comparator or converter
// - guard counts 128 kHz oscillator cycles
// - restart clears guard counter before time-out
// - interrupt mode raises waking interrupt request
// - reset mode time-out resets the chip
// - combined mode: interrupt first, then reset
// - always-on fuse forces reset mode
// - change opens with change and reset enable
// - protected change only within four cycles
// - time-out selectable from 16ms to 8s
// - after guard reset, reset mode stays on
// - change enable self-clears after four cycles
// - guard reset flag forces reset enable
// - prescale code doubles from 2048 cycles
// - irq flag cleared by vector or one
module wrs_top #(
  parameter int unsigned STARTUP_MID = wrs_pkg::STARTUP_MID_CYC,
  parameter int unsigned STARTUP_LONG = wrs_pkg::STARTUP_LONG_CYC
) (
  // clock and block reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // register port
  input wire wrs_pkg::wrs_bus_req_s bus_i,
  output logic [7:0] rdata_o,
  // analog and pin inputs
  input wire wrs_pkg::wrs_analog_s analog_i,
  input wire logic guard_osc_i,
  // static fuses and straps
  input wire logic reset_pin_disable_fuse_i,
  input wire logic guard_always_on_fuse_i,
  input wire logic [2:0] droop_level_fuse_i,
  input wire logic [1:0] startup_sel_i,
  // core side
  input wire logic guard_restart_i,
  input wire logic guard_irq_ack_i,
  input wire logic comparator_bandgap_select_i,
  input wire logic adc_enable_i,
  // outputs
  output logic sys_reset_n_o,
  output logic guard_irq_o,
  output logic bandgap_en_o,
  output logic [2:0] droop_level_o
);
  import wrs_pkg::*;

  typedef struct packed {
    wrs_rst_state_e st;
    logic [DLY_CNT_W-1:0] dly_cnt;
    logic [DROOP_CNT_W-1:0] droop_cnt;
    logic droop_det;
    logic osc_meta;
    logic osc_sync;
    logic osc_prev;
    logic [GUARD_CNT_W-1:0] guard_cnt;
    logic irq_en;
    logic reset_en;
    logic [2:0] ce_cnt;
    logic [3:0] presc;
    logic irq_flag;
    logic [3:0] rst_flags;
    logic [7:0] rdata;
    logic sys_rst_n;
    logic irq;
    logic bandgap;
    logic [2:0] droop_level;
  } wrs_state_s;

  wrs_state_s s_r;
  wrs_state_s s_nxt;

  function automatic logic [DLY_CNT_W-1:0] startup_len(input logic [1:0] sel);
    logic [DLY_CNT_W-1:0] len;
    len = DLY_CNT_W'(STARTUP_SHORT_CYC);
    if (sel == 2'h1) begin
      len = DLY_CNT_W'(STARTUP_MID);
    end else if (sel[1]) begin
      len = DLY_CNT_W'(STARTUP_LONG);
    end
    return len;
  endfunction

  // reserved codes fall back to the longest period rather than stopping
  function automatic logic [GUARD_CNT_W-1:0] guard_last(input logic [3:0] code);
    logic [3:0] c;
    c = (code > PRESC_MAX_CODE) ? PRESC_MAX_CODE : code;
    return GUARD_CNT_W'((GUARD_BASE_CYC << c) - 1);
  endfunction

  logic droop_en;
  logic onset_src;
  logic ext_src;
  logic level_src;
  logic osc_tick;
  logic re_eff;
  logic ie_eff;
  logic timeout;
  logic guard_reset_evt;
  logic ctrl_wr;
  logic stat_wr;
  logic window_open;

  always_comb begin
    droop_en = (droop_level_fuse_i != DROOP_LEVEL_OFF);
    onset_src = ~analog_i.supply_ok;
    ext_src = ~analog_i.ext_reset_n & ~reset_pin_disable_fuse_i;
    level_src = onset_src | ext_src | s_r.droop_det;
    osc_tick = s_r.osc_sync & ~s_r.osc_prev;
    re_eff = s_r.reset_en | s_r.rst_flags[RS_GUARD] | guard_always_on_fuse_i;
    ie_eff = s_r.irq_en & ~guard_always_on_fuse_i;
    timeout = osc_tick & (re_eff | ie_eff) && (s_r.guard_cnt >= guard_last(s_r.presc));
    // unserved interrupt in combined mode escalates to reset
    guard_reset_evt = timeout & re_eff & (~ie_eff | s_r.irq_flag);
    ctrl_wr = bus_i.wr && (bus_i.addr == ADDR_GUARD_CTRL);
    stat_wr = bus_i.wr && (bus_i.addr == ADDR_RST_STATUS);
    window_open = (s_r.ce_cnt != 3'h0);
  end

  always_comb begin
    s_nxt = s_r;

    // oscillator edge into the core domain; meta flop feeds only sync
    s_nxt.osc_meta = guard_osc_i;
    s_nxt.osc_sync = s_r.osc_meta;
    s_nxt.osc_prev = s_r.osc_sync;

    // droop: low threshold must persist; release only above high threshold
    if (!droop_en) begin
      s_nxt.droop_cnt = '0;
      s_nxt.droop_det = 1'b0;
    end else if (analog_i.droop_low) begin
      if (s_r.droop_cnt >= DROOP_CNT_W'(DROOP_MIN_CYC)) begin
        s_nxt.droop_det = 1'b1;
      end else begin
        s_nxt.droop_cnt = s_r.droop_cnt + DROOP_CNT_W'(1);
      end
    end else begin
      s_nxt.droop_cnt = '0;
      if (analog_i.droop_high) begin
        s_nxt.droop_det = 1'b0;
      end
    end

    // reset sequencer
    case (s_r.st)
      WRS_HOLD: begin
        s_nxt.dly_cnt = startup_len(startup_sel_i);
        if (!level_src) begin
          s_nxt.st = WRS_DELAY;
        end
      end
      WRS_DELAY: begin
        if (level_src) begin
          s_nxt.st = WRS_HOLD;
        end else if (s_r.dly_cnt <= DLY_CNT_W'(1)) begin
          s_nxt.st = WRS_RUN;
        end else begin
          s_nxt.dly_cnt = s_r.dly_cnt - DLY_CNT_W'(1);
        end
      end
      WRS_GUARD_PULSE: begin
        s_nxt.dly_cnt = startup_len(startup_sel_i);
        s_nxt.st = level_src ? WRS_HOLD : WRS_DELAY;
      end
      default: begin
        if (level_src) begin
          s_nxt.st = WRS_HOLD;
        end else if (guard_reset_evt) begin
          s_nxt.st = WRS_GUARD_PULSE;
        end
      end
    endcase
    s_nxt.sys_rst_n = (s_nxt.st == WRS_RUN);

    // reset cause flags; hardware set wins over a software clear
    if (stat_wr) begin
      s_nxt.rst_flags = s_r.rst_flags & bus_i.wdata[3:0];
    end
    if (s_r.st == WRS_GUARD_PULSE) begin
      s_nxt.rst_flags[RS_GUARD] = 1'b1;
    end
    if (s_r.droop_det) begin
      s_nxt.rst_flags[RS_DROOP] = 1'b1;
    end
    if (ext_src) begin
      s_nxt.rst_flags[RS_EXT] = 1'b1;
    end
    if (onset_src) begin
      s_nxt.rst_flags = RST_STATUS_RESET;
    end

    // change window count-down
    if (window_open) begin
      s_nxt.ce_cnt = s_r.ce_cnt - 3'h1;
    end

    // guard control writes
    if (ctrl_wr) begin
      s_nxt.irq_en = bus_i.wdata[GC_IRQ_EN];
      if (bus_i.wdata[GC_RESET_EN]) begin
        s_nxt.reset_en = 1'b1;
      end
      if (bus_i.wdata[GC_IRQ_FLAG]) begin
        s_nxt.irq_flag = 1'b0;
      end
      if (bus_i.wdata[GC_CHANGE_EN] && bus_i.wdata[GC_RESET_EN]) begin
        s_nxt.ce_cnt = CHANGE_WINDOW_CYC;
      end else if (window_open && !bus_i.wdata[GC_CHANGE_EN]) begin
        s_nxt.reset_en = bus_i.wdata[GC_RESET_EN];
        s_nxt.presc = {bus_i.wdata[GC_PRESC_HI], bus_i.wdata[GC_PRESC_LO_MSB:0]};
        s_nxt.ce_cnt = 3'h0;
      end
    end

    // vector taken: flag drops; combined mode falls back to reset mode
    if (guard_irq_ack_i) begin
      s_nxt.irq_flag = 1'b0;
      if (re_eff) begin
        s_nxt.irq_en = 1'b0;
      end
    end

    // guard counter
    if (guard_restart_i || timeout) begin
      s_nxt.guard_cnt = '0;
    end else if (osc_tick && (re_eff || ie_eff)) begin
      s_nxt.guard_cnt = s_r.guard_cnt + GUARD_CNT_W'(1);
    end
    if (timeout && ie_eff && !guard_reset_evt) begin
      s_nxt.irq_flag = 1'b1;
    end

    // chip reset returns control to defaults; guard flag keeps reset on
    if (s_r.st != WRS_RUN) begin
      s_nxt.irq_en = GUARD_CTRL_RESET[GC_IRQ_EN];
      s_nxt.reset_en = GUARD_CTRL_RESET[GC_RESET_EN];
      s_nxt.presc = {GUARD_CTRL_RESET[GC_PRESC_HI], GUARD_CTRL_RESET[GC_PRESC_LO_MSB:0]};
      s_nxt.irq_flag = GUARD_CTRL_RESET[GC_IRQ_FLAG];
      s_nxt.ce_cnt = 3'h0;
      s_nxt.guard_cnt = '0;
    end

    // read data, one cycle after the strobe
    s_nxt.rdata = 8'h00;
    if (bus_i.rd) begin
      if (bus_i.addr == ADDR_GUARD_CTRL) begin
        s_nxt.rdata = {s_r.irq_flag, ie_eff, s_r.presc[3], window_open, re_eff,
                       s_r.presc[2:0]};
      end else if (bus_i.addr == ADDR_RST_STATUS) begin
        s_nxt.rdata = {4'h0, s_r.rst_flags};
      end
    end

    // level irq; also serves as wake request while the core sleeps
    s_nxt.irq = s_nxt.irq_flag & ie_eff;
    s_nxt.bandgap = droop_en | comparator_bandgap_select_i | adc_enable_i;
    s_nxt.droop_level = droop_level_fuse_i;
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      s_r <= '{st: WRS_HOLD, rst_flags: RST_STATUS_RESET, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  always_comb begin
    rdata_o = s_r.rdata;
    sys_reset_n_o = s_r.sys_rst_n;
    guard_irq_o = s_r.irq;
    bandgap_en_o = s_r.bandgap;
    droop_level_o = s_r.droop_level;
  end

endmodule

//--- testbench/wrs_checker.sv
`timescale 1ns/10ps
module wrs_checker
  import wrs_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic resetn_i,
  // inputs watched
  input wire wrs_pkg::wrs_bus_req_s bus_i,
  input wire wrs_pkg::wrs_analog_s analog_i,
  input wire logic reset_pin_disable_fuse_i,
  input wire logic [2:0] droop_level_fuse_i,
  input wire logic [1:0] startup_sel_i,
  input wire logic guard_irq_ack_i,
  input wire logic comparator_bandgap_select_i,
  input wire logic adc_enable_i,
  // outputs watched
  input wire logic [7:0] rdata_o,
  input wire logic sys_reset_n_o,
  input wire logic guard_irq_o,
  input wire logic bandgap_en_o,
  input wire logic [2:0] droop_level_o
);
  logic [7:0] low_cnt_r;
  logic bg_cause;
  assign bg_cause = droop_level_fuse_i != DROOP_LEVEL_OFF || comparator_bandgap_select_i
    || adc_enable_i;
  // saturates so a long hold never wraps into a false early release
  always_ff @(posedge mclk_i) begin
    if (!resetn_i || sys_reset_n_o) low_cnt_r <= 8'h00;
    else if (low_cnt_r != 8'hFF) low_cnt_r <= low_cnt_r + 8'h01;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  sequence ack_seen;
    guard_irq_o && guard_irq_ack_i;
  endsequence
  sequence irq_quiet;
    !guard_irq_ack_i && !bus_i.wr && !$past(guard_irq_ack_i) && !$past(bus_i.wr);
  endsequence
  AST_ONSET_HOLD: assert property (!analog_i.supply_ok |=> !sys_reset_n_o)
    else $error("reset not held on low supply");
  AST_PIN_RESET: assert property (!analog_i.ext_reset_n && !reset_pin_disable_fuse_i
    |=> !sys_reset_n_o) else $error("reset pin ignored");
  AST_STARTUP_LEN: assert property ($rose(sys_reset_n_o) && startup_sel_i == 2'h0
    |-> low_cnt_r >= 8'h10) else $error("released before start-up delay");
  AST_BANDGAP: assert property ($past(resetn_i) |=> bandgap_en_o == $past(bg_cause))
    else $error("bandgap enable wrong");
  AST_LEVEL_COPY: assert property ($past(resetn_i)
    |=> droop_level_o == $past(droop_level_fuse_i)) else $error("droop level wrong");
  AST_IRQ_HOLD: assert property (guard_irq_o ##0 irq_quiet
    |=> guard_irq_o || !sys_reset_n_o) else $error("irq dropped uncleared");
  AST_IRQ_ACK: assert property (ack_seen |-> ##[1:2] !guard_irq_o)
    else $error("irq not cleared by ack");
  AST_UNMAPPED: assert property (bus_i.rd && bus_i.addr != ADDR_GUARD_CTRL
    && bus_i.addr != ADDR_RST_STATUS |=> rdata_o == 8'h00) else $error("unmapped read");
endmodule

bind wrs_top wrs_checker u_chk (.mclk_i(mclk_i), .resetn_i(resetn_i), .bus_i(bus_i),
  .analog_i(analog_i), .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i),
  .droop_level_fuse_i(droop_level_fuse_i), .startup_sel_i(startup_sel_i),
  .guard_irq_ack_i(guard_irq_ack_i), .comparator_bandgap_select_i(comparator_bandgap_select_i),
  .adc_enable_i(adc_enable_i), .rdata_o(rdata_o), .sys_reset_n_o(sys_reset_n_o),
  .guard_irq_o(guard_irq_o), .bandgap_en_o(bandgap_en_o), .droop_level_o(droop_level_o));

//--- testbench/wrs_osc_model.sv
`timescale 1ns/10ps
module wrs_osc_model #(
  parameter int HALF = 4
) (
  // core clock
  input wire logic mclk_i,
  // oscillator out
  output logic guard_osc_o
);
  int cnt = 0;
  initial guard_osc_o = 1'b0;
  // far faster than the real oscillator so time-outs fit a short run
  always @(posedge mclk_i) begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1) guard_osc_o <= ~guard_osc_o;
  end
endmodule

//--- testbench/wrs_top_tb_top.sv
`timescale 1ns/10ps
module wrs_top_tb_top;
  import wrs_pkg::*;
  logic mclk_i = 1'b0;
  logic resetn_i = 1'b0;
  wrs_bus_req_s bus_i = '0;
  wrs_analog_s analog_i = 4'hD;
  logic guard_osc_i, sys_reset_n_o, guard_irq_o, bandgap_en_o;
  logic guard_restart_i = 1'b0;
  logic guard_irq_ack_i = 1'b0;
  logic comparator_bandgap_select_i = 1'b0;
  logic adc_enable_i = 1'b0;
  logic reset_pin_disable_fuse_i = 1'b0;
  logic rd_q = 1'b0;
  logic [7:0] rdata_o, e;
  logic [7:0] exp_q[$];
  int seed = 32'hcfbd;
  int error_cnt = 0;
  int comparisons = 0;
  int n;
  always #(CLK_PERIOD_NS / 2) mclk_i = ~mclk_i;
  wrs_osc_model u_osc (.mclk_i(mclk_i), .guard_osc_o(guard_osc_i));
  wrs_top #(.STARTUP_MID(40), .STARTUP_LONG(80)) DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
    .bus_i(bus_i), .rdata_o(rdata_o), .analog_i(analog_i), .guard_osc_i(guard_osc_i),
    .reset_pin_disable_fuse_i(reset_pin_disable_fuse_i), .guard_always_on_fuse_i(1'b0),
    .droop_level_fuse_i(3'h7), .startup_sel_i(2'h0), .guard_restart_i(guard_restart_i),
    .guard_irq_ack_i(guard_irq_ack_i), .comparator_bandgap_select_i(comparator_bandgap_select_i),
    .adc_enable_i(adc_enable_i), .sys_reset_n_o(sys_reset_n_o), .guard_irq_o(guard_irq_o),
    .bandgap_en_o(bandgap_en_o), .droop_level_o());
  task test_done();
    if (error_cnt == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i) bus_i <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk_i) bus_i <= '0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    @(posedge mclk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge mclk_i) bus_i <= '0;
  endtask
  task pls(input bit ack);
    @(posedge mclk_i) {guard_irq_ack_i, guard_restart_i} <= {ack, !ack};
    @(posedge mclk_i) {guard_irq_ack_i, guard_restart_i} <= 2'h0;
  endtask
  // sel 1 waits on the irq line, 0 on the chip reset line
  task wt(input bit s, input logic v, input int lim);
    n = 0;
    @(negedge mclk_i);
    while ((s ? guard_irq_o : sys_reset_n_o) !== v && n < lim) begin
      @(negedge mclk_i);
      n++;
    end
    comparisons++;
    if (n >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait exp %h got %h", $time, v, !v);
    end
  endtask
  always @(posedge mclk_i) begin
    rd_q <= bus_i.rd;
    if (rd_q) begin
      e = exp_q.pop_front();
      comparisons++;
      if (rdata_o !== e) begin
        error_cnt++;
        $display("[ERR] %0t exp %h got %h", $time, e, rdata_o);
      end
    end
  end
  initial begin
    repeat (90000) @(posedge mclk_i);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge mclk_i);
    resetn_i <= 1'b1;
    wt(0, 1'b1, 100);
    rd(8'h35, 8'h01);
    rd(8'h80 | 8'($random(seed)), 8'h00);
    rd(8'h60, 8'h00);
    wr(8'h60, 8'h08);
    wr(8'h60, 8'h18);
    repeat (5) @(posedge mclk_i);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h08);
    wr(8'h60, 8'h18);
    wr(8'h60, 8'h00);
    rd(8'h60, 8'h00);
    repeat (16) @(posedge mclk_i) {comparator_bandgap_select_i, adc_enable_i} <= 2'($random(seed));
    wr(8'h60, 8'h40);
    pls(0);
    wt(1, 1'b1, 20000);
    rd(8'h60, 8'hC0);
    pls(1);
    rd(8'h60, 8'h40);
    repeat (2) begin
      pls(0);
      repeat (9000) @(posedge mclk_i);
    end
    rd(8'h60, 8'h40);
    wr(8'h60, 8'h48);
    pls(0);
    wt(1, 1'b1, 20000);
    wt(0, 1'b0, 20000);
    wt(0, 1'b1, 100);
    rd(8'h35, 8'h09);
    rd(8'h60, 8'h08);
    @(posedge mclk_i) analog_i.ext_reset_n <= 1'b0;
    repeat (1 + ($random(seed) & 3)) @(posedge mclk_i);
    analog_i.ext_reset_n <= 1'b1;
    wt(0, 1'b1, 100);
    rd(8'h35, 8'h0B);
    @(posedge mclk_i) analog_i.supply_ok <= 1'b0;
    repeat (3) @(posedge mclk_i);
    analog_i.supply_ok <= 1'b1;
    wt(0, 1'b1, 100);
    rd(8'h35, 8'h01);
    wr(8'h35, 8'h00);
    rd(8'h35, 8'h00);
    @(posedge mclk_i) reset_pin_disable_fuse_i <= 1'b1;
    @(posedge mclk_i) analog_i.ext_reset_n <= 1'b0;
    repeat (3) @(posedge mclk_i);
    analog_i.ext_reset_n <= 1'b1;
    @(posedge mclk_i) reset_pin_disable_fuse_i <= 1'b0;
    rd(8'h35, 8'h00);
    test_done();
  end
endmodule
